// >>> mlcc_pkg.sv
/*
 * Constants of the modem line block: register indices, byte addresses,
 * field positions and reset values.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
 */
package mlcc_pkg;
   // ==========================================================
   // Register indices and byte addresses
   // ==========================================================
   localparam logic [7:0] IDX_ASSERT_EN = 8'h10;
   localparam logic [7:0] IDX_DEASSERT_EN = 8'h11;
   localparam logic [7:0] IDX_CHANGE = 8'h12;
   localparam logic [7:0] IDX_VALUES = 8'h28;
   localparam logic [7:0] IDX_RTS_ONLY = 8'h29;
   localparam logic [7:0] IDX_DTR_ONLY = 8'h2A;
   localparam logic [7:0] ADDR_ASSERT_EN = 8'(IDX_ASSERT_EN * 4);
   localparam logic [7:0] ADDR_DEASSERT_EN = 8'(IDX_DEASSERT_EN * 4);
   localparam logic [7:0] ADDR_CHANGE = 8'(IDX_CHANGE * 4);
   localparam logic [7:0] ADDR_VALUES = 8'(IDX_VALUES * 4);
   localparam logic [7:0] ADDR_RTS_ONLY = 8'(IDX_RTS_ONLY * 4);
   localparam logic [7:0] ADDR_DTR_ONLY = 8'(IDX_DTR_ONLY * 4);
   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int BIT_DSR = 7;
   localparam int BIT_CD = 6;
   localparam int BIT_CTS = 5;
   localparam int BIT_DTR = 1;
   localparam int BIT_RTS = 0;
   localparam int IN_LSB = BIT_CTS;
   localparam int IN_MSB = BIT_DSR;
   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [2:0] RST_ENABLES = 3'h0;
   localparam logic [2:0] RST_CHANGE = 3'h0;
   localparam logic [2:0] RST_PIN_SYNC = 3'h7;
   localparam logic RST_PIN_OUT = 1'h1;
   localparam logic RST_WAIT = 1'h1;
   localparam logic [31:0] RST_RDATA = 32'h0;
endpackage

// >>> mlcc_sync.sv
/*
 * Two-stage synchroniser for the three modem input pins.
 * Assumes the pins are asynchronous to clk_in and idle high.
 */
`timescale 1ns/10ps
module mlcc_sync (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] pins_n_in,
   output logic [2:0] pins_n_out
);
   logic [2:0] stage1_ff;
   logic [2:0] stage2_ff;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stage1_ff <= mlcc_pkg::RST_PIN_SYNC;
         stage2_ff <= mlcc_pkg::RST_PIN_SYNC;
      end else begin
         stage1_ff <= pins_n_in; // [R13]
         stage2_ff <= stage1_ff;
      end
   end

   assign pins_n_out = stage2_ff;
endmodule // mlcc_sync

// >>> mlcc_edge.sv
/*
 * Transition detector for the three modem value bits.
 * Assumes value_in is already synchronous to clk_in; bit 2 is DSR, 1 CD, 0 CTS.
 */
`timescale 1ns/10ps
module mlcc_edge (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] value_in,
   input wire logic [2:0] rise_en_in,
   input wire logic [2:0] fall_en_in,
   output logic [2:0] change_out
);
   logic [2:0] prev_ff;
   wire logic [2:0] rose_w = value_in & ~prev_ff;
   wire logic [2:0] fell_w = ~value_in & prev_ff;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prev_ff <= ~mlcc_pkg::RST_PIN_SYNC;
      end else begin
         prev_ff <= value_in; // [R13]
      end
   end

   assign change_out = (rose_w & rise_en_in) | (fell_w & fall_en_in); // [R1] [R2] [R3] [R11]

   a_dsr_fall_flag: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1]
      $fell(value_in[2]) && fall_en_in[2] |-> change_out[2])
      else $error("DSR deassert not flagged");
   a_cd_fall_flag: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R2]
      $fell(value_in[1]) && fall_en_in[1] |-> change_out[1])
      else $error("CD deassert not flagged");
   a_cts_fall_flag: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R3]
      $fell(value_in[0]) && fall_en_in[0] |-> change_out[0])
      else $error("CTS deassert not flagged");
   a_assert_flags: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R11]
      ((value_in & ~$past(value_in) & rise_en_in) & ~change_out) == 3'h0)
      else $error("Assert transition not flagged");
   a_change_cause: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R13]
      (change_out != 3'h0) |-> ((change_out & (value_in ^ $past(value_in))) == change_out))
      else $error("Change flagged without transition");
endmodule // mlcc_edge

// >>> mlcc_modem_line.sv
/*
 * Modem line block of one channel: synchronised DSR, CD and CTS inputs with
 * programmable transition detection, the DTR and RTS outputs, and the
 * register file behind an Avalon-MM slave with waitrequest.
 * Assumes a master that holds each request until waitrequest is sampled low.
 */
`timescale 1ns/10ps
// Notes on behaviour
// [R1] With its deassert enable set, a DSR pin rising sets the DSR change flag.
// [R2] With its deassert enable set, a CD pin rising sets the CD change flag.
// [R3] With its deassert enable set, a CTS pin rising sets the CTS change flag.
// [R4] Value register reads give DSR, CD, CTS levels in bits 7, 6, 5.
// [R5] Value register writes load RTS from bit 0 and DTR from bit 1.
// [R6] Value bits are inverse of pins: one drives low, low reads one.
// [R7] Value bits 1:0 read back DTR and RTS; bits 4:2 read zero.
// [R8] A value register write always rewrites both DTR and RTS; here a write with byteenable bit 0 clear changes neither.
// [R9] The RTS-only register changes RTS from bit 0 and nothing else.
// [R10] The DTR-only register changes DTR from bit 1 and nothing else.
// [R11] Assert enables flag falling DSR, CD and CTS pins likewise.
// [R12] Each enabled transition sets its bit 7, 6 or 5 in the change register.
// [R13] Inputs are synchronised and compared with the previous clock's sample.
// [R14] Software writes zero to unused bits of option and single-output registers.
module mlcc_modem_line (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic dsr_n_in,
   input wire logic cd_n_in,
   input wire logic cts_n_in,
   output logic dtr_n_out,
   output logic rts_n_out
);
   // ==========================================================
   // Functions
   // ==========================================================
   // Address match for one register word.
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   // Places the three input-side bits into their byte positions.
   function automatic logic [7:0] in_byte(input logic [2:0] bits);
      logic [7:0] b;
      b = 8'h00;
      b[mlcc_pkg::IN_MSB:mlcc_pkg::IN_LSB] = bits;
      return b;
   endfunction

   // ==========================================================
   // Registers
   // ==========================================================
   logic waitrequest_ff;
   logic nxt_waitrequest;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic [2:0] assert_en_ff;
   logic [2:0] nxt_assert_en;
   logic [2:0] deassert_en_ff;
   logic [2:0] nxt_deassert_en;
   logic [2:0] change_ff;
   logic [2:0] nxt_change;
   logic dtr_n_ff;
   logic nxt_dtr_n;
   logic rts_n_ff;
   logic nxt_rts_n;

   // ==========================================================
   // Modem inputs
   // ==========================================================
   logic [2:0] pins_sync_n;
   logic [2:0] change_pulse;

   mlcc_sync u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .pins_n_in({dsr_n_in, cd_n_in, cts_n_in}),
      .pins_n_out(pins_sync_n)
   );

   // Value bits carry the inverse of the pin levels.
   wire logic [2:0] line_values = ~pins_sync_n; // [R6]

   mlcc_edge u_edge (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .value_in(line_values),
      .rise_en_in(assert_en_ff),
      .fall_en_in(deassert_en_ff),
      .change_out(change_pulse)
   );

   // ==========================================================
   // Bus decode
   // ==========================================================
   wire logic req = read_in | write_in;
   wire logic take = req & ~waitrequest_ff;
   wire logic lane0 = byteenable_in[0];
   wire logic wr_take = write_in & take & lane0;
   wire logic rd_first = read_in & waitrequest_ff;
   wire logic sel_assert = hit(address_in, mlcc_pkg::ADDR_ASSERT_EN);
   wire logic sel_deassert = hit(address_in, mlcc_pkg::ADDR_DEASSERT_EN);
   wire logic sel_change = hit(address_in, mlcc_pkg::ADDR_CHANGE);
   wire logic sel_values = hit(address_in, mlcc_pkg::ADDR_VALUES);
   wire logic sel_rts = hit(address_in, mlcc_pkg::ADDR_RTS_ONLY);
   wire logic sel_dtr = hit(address_in, mlcc_pkg::ADDR_DTR_ONLY);
   wire logic [7:0] wbyte = writedata_in[7:0];
   wire logic [2:0] wbits = wbyte[mlcc_pkg::IN_MSB:mlcc_pkg::IN_LSB];

   // Value register image: inputs high, driven outputs low, bits 4:2 zero.
   wire logic [7:0] values_image = in_byte(line_values) // [R4]
      | {6'h00, ~dtr_n_ff, ~rts_n_ff}; // [R7]

   // Single-output registers and unmapped words read as zero.
   wire logic [7:0] read_byte =
      sel_assert ? in_byte(assert_en_ff) :
      sel_deassert ? in_byte(deassert_en_ff) :
      sel_change ? in_byte(change_ff) :
      sel_values ? values_image :
      8'h00;

   // ==========================================================
   // Next-state logic
   // ==========================================================
   // One wait cycle, then the answer cycle in which the access is taken.
   always_comb begin
      nxt_waitrequest = mlcc_pkg::RST_WAIT;
      if (req && waitrequest_ff) begin
         nxt_waitrequest = 1'h0;
      end
   end

   always_comb begin
      nxt_readdata = readdata_ff;
      if (rd_first) begin
         nxt_readdata = {24'h000000, read_byte};
      end
   end

   always_comb begin
      nxt_assert_en = assert_en_ff;
      nxt_deassert_en = deassert_en_ff;
      if (wr_take && sel_assert) begin
         nxt_assert_en = wbits; // [R11]
      end
      if (wr_take && sel_deassert) begin
         nxt_deassert_en = wbits; // [R1] [R2] [R3]
      end
   end

   // Writing ones clears change bits; a new transition in the same cycle wins.
   always_comb begin
      nxt_change = change_ff;
      if (wr_take && sel_change) begin
         nxt_change = change_ff & ~wbits;
      end
      nxt_change = nxt_change | change_pulse; // [R12]
   end

   always_comb begin
      nxt_dtr_n = dtr_n_ff;
      nxt_rts_n = rts_n_ff;
      if (wr_take && sel_values) begin
         nxt_dtr_n = ~wbyte[mlcc_pkg::BIT_DTR]; // [R5] [R6] [R8]
         nxt_rts_n = ~wbyte[mlcc_pkg::BIT_RTS]; // [R5] [R6] [R8]
      end
      if (wr_take && sel_rts) begin
         nxt_rts_n = ~wbyte[mlcc_pkg::BIT_RTS]; // [R9]
      end
      if (wr_take && sel_dtr) begin
         nxt_dtr_n = ~wbyte[mlcc_pkg::BIT_DTR]; // [R10]
      end
   end

   // ==========================================================
   // Flip-flops
   // ==========================================================
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         waitrequest_ff <= mlcc_pkg::RST_WAIT;
         readdata_ff <= mlcc_pkg::RST_RDATA;
      end else begin
         waitrequest_ff <= nxt_waitrequest;
         readdata_ff <= nxt_readdata;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         assert_en_ff <= mlcc_pkg::RST_ENABLES;
         deassert_en_ff <= mlcc_pkg::RST_ENABLES;
         change_ff <= mlcc_pkg::RST_CHANGE;
      end else begin
         assert_en_ff <= nxt_assert_en;
         deassert_en_ff <= nxt_deassert_en;
         change_ff <= nxt_change;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dtr_n_ff <= mlcc_pkg::RST_PIN_OUT;
         rts_n_ff <= mlcc_pkg::RST_PIN_OUT;
      end else begin
         dtr_n_ff <= nxt_dtr_n;
         rts_n_ff <= nxt_rts_n;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign readdata_out = readdata_ff;
   assign waitrequest_out = waitrequest_ff;
   assign dtr_n_out = dtr_n_ff;
   assign rts_n_out = rts_n_ff;

   // ==========================================================
   // Checks
   // ==========================================================
   wire logic chk_rd_values = rd_first & sel_values;
   wire logic chk_wr_values = wr_take & sel_values;
   wire logic chk_wr_rts = wr_take & sel_rts;
   wire logic chk_wr_dtr = wr_take & sel_dtr;

   a_input_readback: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R4]
      chk_rd_values |=> readdata_out[7:5] == ~$past(pins_sync_n))
      else $error("Value read does not show input levels");

   a_value_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R5]
      chk_wr_values |=> rts_n_out == ~$past(writedata_in[0]) && dtr_n_out == ~$past(writedata_in[1]))
      else $error("Value write did not load outputs");

   a_one_drives_low: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R6]
      chk_wr_values && writedata_in[0] |=> !rts_n_out [*2])
      else $error("Writing one did not drive RTS low");

   a_output_readback: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R7]
      chk_rd_values |=> readdata_out[4:0] == {3'h0, ~$past(dtr_n_out), ~$past(rts_n_out)})
      else $error("Value read does not show driven outputs");

   a_both_rewritten: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R8]
      chk_wr_values && writedata_in[1] == dtr_n_out |=> $changed(dtr_n_out))
      else $error("Value write left DTR unchanged");

   a_rts_only_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R9]
      chk_wr_rts |=> rts_n_out == ~$past(writedata_in[0]) && $stable(dtr_n_out))
      else $error("RTS-only write misbehaved");

   a_dtr_only_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R10]
      chk_wr_dtr |=> dtr_n_out == ~$past(writedata_in[1]) && $stable(rts_n_out))
      else $error("DTR-only write misbehaved");

   a_change_sticky: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
      change_pulse != 3'h0 |=> (change_ff & $past(change_pulse)) == $past(change_pulse))
      else $error("Transition did not set change bit");

   a_wait_one_cycle: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req && waitrequest_ff |=> !waitrequest_ff ##1 waitrequest_ff)
      else $error("Answer latency is not one cycle");

   a_idle_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !req && waitrequest_ff |=> waitrequest_ff)
      else $error("Waitrequest dropped without a request");

   a_read_stands: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !rd_first |=> $stable(readdata_out))
      else $error("Read data changed without a read");

   // ==========================================================
   // Register checks
   // ==========================================================
   wire logic chk_wr_change = wr_take & sel_change;
   wire logic chk_wr_dropped = write_in & take & ~lane0;
   wire logic chk_rd_zero = rd_first & ~(sel_assert | sel_deassert | sel_change | sel_values);
   wire logic chk_wr_enables = wr_take & (sel_assert | sel_deassert);

   a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
      chk_rd_zero |=> readdata_out == 32'h00000000)
      else $error("Write-only or unmapped word did not read zero");

   a_deassert_en_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1] [R2] [R3]
      wr_take && sel_deassert |=> deassert_en_ff == $past(wbits))
      else $error("Deassert enables not loaded");

   a_assert_en_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R11]
      wr_take && sel_assert |=> assert_en_ff == $past(wbits))
      else $error("Assert enables not loaded");

   a_enables_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !chk_wr_enables |=> $stable(assert_en_ff) && $stable(deassert_en_ff))
      else $error("Enables changed without a write");

   a_deassert_readback: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1]
      rd_first && sel_deassert |=> readdata_out[7:5] == $past(deassert_en_ff))
      else $error("Deassert enables read back wrong");

   a_assert_readback: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R11]
      rd_first && sel_assert |=> readdata_out[7:5] == $past(assert_en_ff))
      else $error("Assert enables read back wrong");

   a_change_clear: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
      chk_wr_change && change_pulse == 3'h0 |=> (change_ff & $past(wbits)) == 3'h0)
      else $error("Change bits not cleared by write");

   a_change_hold: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
      !chk_wr_change |=> (change_ff & $past(change_ff)) == $past(change_ff))
      else $error("Change bit lost without a clear");

   a_change_no_spurious: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
      (change_ff & ~$past(change_ff) & ~$past(change_pulse)) == 3'h0)
      else $error("Change bit set without a transition");

   a_change_readback: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
      rd_first && sel_change |=> readdata_out[7:5] == $past(change_ff))
      else $error("Change bits read back wrong");

   a_disabled_no_flag: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1] [R11]
      (change_pulse & ~(assert_en_ff | deassert_en_ff)) == 3'h0)
      else $error("Transition flagged with its enables clear");

   // ==========================================================
   // Output checks
   // ==========================================================
   wire logic chk_wr_outputs = wr_take & (sel_values | sel_rts | sel_dtr);

   a_pins_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !chk_wr_outputs |=> $stable(dtr_n_out) && $stable(rts_n_out))
      else $error("Modem output changed without a write");

   a_lane_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
      chk_wr_dropped |=> $stable(dtr_n_out) && $stable(rts_n_out)
         && $stable(assert_en_ff) && $stable(deassert_en_ff))
      else $error("Write without lane zero took effect");

   a_dtr_one_low: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R6]
      chk_wr_values && writedata_in[1] |=> !dtr_n_out)
      else $error("Writing one did not drive DTR low");

   a_zero_drives_high: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R6]
      chk_wr_values && !writedata_in[1] |=> dtr_n_out)
      else $error("Writing zero did not drive DTR high");
endmodule // mlcc_modem_line

// >>> mlcc_dce_model.sv
/*
 * Behavioural model of the far-end modem that drives the DSR, CD and CTS lines.
 * Assumes the bench requests line states as active-high levels; the model
 * delays each request by LAG clocks and drives the active-low pins.
 */
`timescale 1ns/10ps
module mlcc_dce_model #(
   parameter int LAG = 2
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] lines_req_in,
   output logic dsr_n_out,
   output logic cd_n_out,
   output logic cts_n_out
);
   // ==========================================================
   // Delayed line driver
   // ==========================================================
   logic [2:0] stage_ff [LAG];

   // The pins are always driven, so an idle line sits at its deasserted high level.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < LAG; i++) begin
            stage_ff[i] <= 3'h0;
         end
      end else begin
         stage_ff[0] <= lines_req_in;
         for (int i = 1; i < LAG; i++) begin
            stage_ff[i] <= stage_ff[i - 1];
         end
      end
   end

   assign dsr_n_out = ~stage_ff[LAG - 1][2];
   assign cd_n_out = ~stage_ff[LAG - 1][1];
   assign cts_n_out = ~stage_ff[LAG - 1][0];
endmodule // mlcc_dce_model

// >>> modem_line_change_control_test.sv
/*
 * Self-checking bench of the modem line block: register accesses over
 * Avalon-MM and modem line changes driven through the far-end model.
 * Assumes the package constants and a one-wait-cycle slave.
 */
`timescale 1ns/10ps
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module modem_line_change_control_test;
   // ==========================================================
   // Signals and instances
   // ==========================================================
   localparam int LAG = 2;
   localparam int SETTLE = LAG + 5;
   logic clk_in, rstn_in, read, write, waitrequest, dsr_n, cd_n, cts_n, dtr_n, rts_n;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [2:0] lines_req;
   logic [31:0] rd;
   logic [7:0] mask;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;

   mlcc_modem_line uut (.clk_in(clk_in), .rstn_in(rstn_in), .address_in(address), .read_in(read),
      .write_in(write), .writedata_in(writedata), .byteenable_in(byteenable), .readdata_out(readdata),
      .waitrequest_out(waitrequest), .dsr_n_in(dsr_n), .cd_n_in(cd_n), .cts_n_in(cts_n),
      .dtr_n_out(dtr_n), .rts_n_out(rts_n));
   mlcc_dce_model #(.LAG(LAG)) dce (.clk_in(clk_in), .rstn_in(rstn_in), .lines_req_in(lines_req),
      .dsr_n_out(dsr_n), .cd_n_out(cd_n), .cts_n_out(cts_n));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // ==========================================================
   // Bus tasks and the closing report
   // ==========================================================
   task automatic bus_write(input logic [7:0] addr, input logic [7:0] data, input logic [3:0] be);
      @(posedge clk_in);
      address <= addr;
      writedata <= {24'h0, data};
      byteenable <= be;
      write <= 1'b1;
      @(posedge clk_in);
      while (waitrequest !== 1'b0) @(posedge clk_in);
      write <= 1'b0;
   endtask

   task automatic chk_read(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge clk_in);
      address <= addr;
      read <= 1'b1;
      @(posedge clk_in);
      while (waitrequest !== 1'b0) @(posedge clk_in);
      rd = readdata;
      read <= 1'b0;
      `CHECK(rd, 32'(exp))
   endtask

   task automatic pins_are(input logic [1:0] exp);
      @(negedge clk_in);
      `CHECK({dtr_n, rts_n}, exp)
   endtask

   task automatic final_report;
      $display("Checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         final_report();
      end
   end

   // ==========================================================
   // Test sequence
   // ==========================================================
   initial begin
      rstn_in = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      lines_req = 3'h0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      chk_read(mlcc_pkg::ADDR_DEASSERT_EN, 8'h00);
      chk_read(mlcc_pkg::ADDR_VALUES, 8'h00);
      pins_are(2'b11);
      bus_write(mlcc_pkg::ADDR_VALUES, 8'h1F, 4'hF);
      pins_are(2'b00);
      chk_read(mlcc_pkg::ADDR_VALUES, 8'h03);
      bus_write(mlcc_pkg::ADDR_VALUES, 8'h01, 4'hF);
      pins_are(2'b10);
      chk_read(mlcc_pkg::ADDR_VALUES, 8'h01);
      bus_write(mlcc_pkg::ADDR_DTR_ONLY, 8'h02, 4'hF);
      pins_are(2'b00);
      bus_write(mlcc_pkg::ADDR_RTS_ONLY, 8'h00, 4'hF);
      pins_are(2'b01);
      chk_read(mlcc_pkg::ADDR_VALUES, 8'h02);
      bus_write(mlcc_pkg::ADDR_VALUES, 8'h03, 4'h0);
      pins_are(2'b01);
      bus_write(8'h3C, 8'hFF, 4'hF);
      chk_read(8'h3C, 8'h00);
      for (int i = 0; i < 3; i++) begin
         mask = 8'h80 >> i;
         bus_write(mlcc_pkg::ADDR_ASSERT_EN, 8'h00, 4'hF);
         bus_write(mlcc_pkg::ADDR_DEASSERT_EN, mask, 4'hF);
         bus_write(mlcc_pkg::ADDR_CHANGE, 8'hE0, 4'hF);
         lines_req <= 3'b100 >> i;
         repeat (SETTLE) @(posedge clk_in);
         chk_read(mlcc_pkg::ADDR_CHANGE, 8'h00);
         chk_read(mlcc_pkg::ADDR_VALUES, mask | 8'h02);
         lines_req <= 3'h0;
         repeat (SETTLE) @(posedge clk_in);
         chk_read(mlcc_pkg::ADDR_CHANGE, mask);
         bus_write(mlcc_pkg::ADDR_DEASSERT_EN, 8'h00, 4'hF);
         bus_write(mlcc_pkg::ADDR_ASSERT_EN, mask, 4'hF);
         bus_write(mlcc_pkg::ADDR_CHANGE, 8'hE0, 4'hF);
         lines_req <= 3'b100 >> i;
         repeat (SETTLE) @(posedge clk_in);
         chk_read(mlcc_pkg::ADDR_CHANGE, mask);
         bus_write(mlcc_pkg::ADDR_CHANGE, 8'hE0, 4'hF);
         chk_read(mlcc_pkg::ADDR_CHANGE, 8'h00);
         lines_req <= 3'h0;
         repeat (SETTLE) @(posedge clk_in);
         chk_read(mlcc_pkg::ADDR_CHANGE, 8'h00);
      end
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      pins_are(2'b11);
      chk_read(mlcc_pkg::ADDR_ASSERT_EN, 8'h00);
      chk_read(mlcc_pkg::ADDR_VALUES, 8'h00);
      final_report();
   end
endmodule // modem_line_change_control_test
